/* pls_self_test.sv */
/*
 * Loopback and pseudo-random self-test logic of a 10/100 transceiver,
 * with its serial management register file and a two-entry receive
 * buffer between the data sources and the MII receive outputs.
 * Assumes all inputs synchronous to mclk_i, the management clock
 * sampled as a plain input, and line coding kept outside this block.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - loopback control bit 14 routes MII transmit data to receive outputs
// - transceiver status bit 3 shows whether loopback is on
// - during loopback nothing is sent onto the twisted pair
// - self-test shares the normal transmit and receive paths, sequence sent in packets with gaps
// - sequence select bit picks a 9-bit or 15-bit pattern
// - received data is compared with the local generator for pass/fail
// - self-test status resets to fail, becomes pass on a good compare
// - a mis-compare latches status until the next start/stop write
// - extension bit 5 makes the self-test transmit without pause
// - self-test errors counted in extension register bits 15:8
// - self-test works with internal loopback or an external cable loop
// - offset 05h shows base page or next page partner ability
// - identifier registers 02h and 03h are read-only
// - basic mode status 01h is read-only, shows abilities and status
// - test extension register sits at 1Bh; bits 5:4 and 2:0 are read/write, error count bits 15:8 read-only
module pls_self_test #(
    parameter logic [4:0] PHY_ADDR = 5'h01,
    parameter logic [15:0] ID_HIGH = 16'h1234,  // arbitrary identity value
    parameter logic [15:0] ID_LOW = 16'h5678,   // arbitrary identity value
    parameter logic [15:0] ABILITY = 16'h7800,
    parameter logic [7:0] PKT_NIBBLES = 8'h40,
    parameter logic [7:0] GAP_CYCLES = 8'h18
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire logic tx_en_i,
    input wire logic [3:0] txd_i,
    output logic tx_ready_o,
    output logic rx_dv_o,
    output logic [3:0] rxd_o,
    input wire logic rx_ready_i,
    output logic media_tx_en_o,
    output logic [3:0] media_txd_o,
    input wire logic media_rx_dv_i,
    input wire logic [3:0] media_rxd_i,
    input wire logic link_i,
    input wire logic speed_100_i,
    input wire logic full_duplex_i,
    input wire logic autoneg_complete_i,
    input wire logic remote_fault_i,
    input wire logic jabber_i,
    input wire logic next_page_view_i
);
    import pls_pkg::*;

    if (PKT_NIBBLES == 8'h00 || GAP_CYCLES == 8'h00) begin : g_chk
        $error("packet length and gap must both be at least one");
    end

    typedef struct packed {
        pls_mdio_e ms;
        logic mdc_q;
        logic [4:0] bcnt;
        logic [15:0] sh;
        logic rd;
        logic [4:0] ra;
        logic mdio_o;
        logic mdio_oe;
        logic [31:0][15:0] gp;
        logic [15:0] pnp;
        logic run;
        logic pass;
        logic lat;
        logic [7:0] err;
        logic [14:0] glfsr;
        logic [14:0] clfsr;
        logic [7:0] pcnt;
        logic gap;
        logic [1:0] fill;
        logic [3:0] b0;
        logic [3:0] b1;
        logic in_rdy;
        logic tx_rdy;
        logic rx_dv;
        logic med_en;
        logic [3:0] med_d;
    } pls_state_s;

    pls_state_s q;
    pls_state_s next_q;

    // plain read/write storage offsets; everything else is special or reserved
    function automatic logic pls_is_rw(input logic [4:0] a);
        return a == OFF_BASIC_MODE_CONTROL || a == OFF_AUTONEG_ADVERTISEMENT ||
               a == OFF_AUTONEG_EXPANSION || a == OFF_AUTONEG_NEXT_PAGE_TRANSMIT ||
               a == OFF_INTERRUPT_CONTROL || a == OFF_CODING_SUBLAYER_CONFIG ||
               a == OFF_REDUCED_MII_BYPASS_CONTROL || a == OFF_INDICATOR_DIRECT_CONTROL ||
               a == OFF_TEN_MEG_STATUS_CONTROL || a == OFF_ENERGY_DETECT_CONTROL;
    endfunction

    logic loop_q;
    logic long_q;
    logic cont_q;
    logic rise;
    logic [15:0] rdv;
    logic [13:0] hdr;
    logic [15:0] wdat;
    logic wr_stb;
    logic gen_active;
    logic gen_fire;
    logic push;
    logic pop;
    logic [3:0] din;
    logic chk;
    logic mis;
    logic start_rise;

    assign loop_q = q.gp[OFF_BASIC_MODE_CONTROL][BMC_LOOPBACK_BIT];
    assign long_q = q.gp[OFF_TRANSCEIVER_CONTROL][TCR_LONG_SEQUENCE_SELECT_BIT];
    assign cont_q = q.gp[OFF_TEST_AND_SELFTEST_EXTENSION][EXT_SELFTEST_CONTINUOUS_BIT];
    assign rise = mdc_i & ~q.mdc_q;
    assign hdr = {q.sh[12:0], mdio_i};
    assign wdat = {q.sh[14:0], mdio_i};
    assign wr_stb = rise && q.ms == PLS_DATA && !q.rd && q.bcnt == MDIO_DATA_LAST;
    assign start_rise = wr_stb && q.ra == OFF_TRANSCEIVER_CONTROL &&
                        wdat[TCR_SELFTEST_START_BIT] && !q.run;

    // read view of the register addressed by the current frame
    always_comb begin
        rdv = 16'h0000;
        if (pls_is_rw(q.ra)) begin
            rdv = q.gp[q.ra];
        end
        unique case (q.ra)
            OFF_BASIC_MODE_STATUS: begin
                rdv = ABILITY | {10'h000, autoneg_complete_i, remote_fault_i, 1'b1,
                                 link_i, jabber_i, 1'b1};
            end
            OFF_IDENTIFIER_HIGH: rdv = ID_HIGH;
            OFF_IDENTIFIER_LOW: rdv = ID_LOW;
            OFF_PARTNER_ABILITY: begin
                rdv = next_page_view_i ? q.pnp : q.gp[OFF_PARTNER_ABILITY];
            end
            OFF_TRANSCEIVER_STATUS: begin
                rdv = {9'h000, remote_fault_i, jabber_i, autoneg_complete_i,
                       loop_q, full_duplex_i, speed_100_i, link_i};
            end
            OFF_TRANSCEIVER_CONTROL: begin
                rdv = q.gp[OFF_TRANSCEIVER_CONTROL];
                rdv[TCR_SELFTEST_STATUS_BIT] = q.pass;
                rdv[TCR_SELFTEST_START_BIT] = q.run;
            end
            OFF_TEST_AND_SELFTEST_EXTENSION: begin
                rdv = {q.err, 8'h00} |
                      (q.gp[OFF_TEST_AND_SELFTEST_EXTENSION] & EXT_WRITABLE_MASK);
            end
            default: ;
        endcase
    end

    // generator, buffer and checker handshakes
    always_comb begin
        gen_active = q.run && (cont_q || !q.gap);
        gen_fire = gen_active && (!loop_q || q.in_rdy);
        if (loop_q) begin
            push = q.run ? gen_fire : (tx_en_i && q.in_rdy);
            din = q.run ? q.glfsr[3:0] : txd_i;
        end else begin
            // no stall on the media side: a word arriving into a full buffer is dropped
            push = media_rx_dv_i && q.in_rdy;
            din = media_rxd_i;
        end
        pop = q.rx_dv && rx_ready_i;
        chk = pop && q.run;
        mis = chk && (q.b0 != q.clfsr[3:0]);
    end

    // next state: management frame, registers, self-test, buffer
    always_comb begin
        next_q = q;
        next_q.mdc_q = mdc_i;
        if (rise) begin
            unique case (q.ms)
                PLS_IDLE: begin
                    if (!mdio_i) begin
                        next_q.ms = PLS_HDR;
                        next_q.bcnt = 5'd1;
                        next_q.sh = 16'h0000;
                    end
                end
                PLS_HDR: begin
                    next_q.sh = wdat;
                    next_q.bcnt = 5'(q.bcnt + 5'd1);
                    if (q.bcnt == MDIO_HDR_LAST) begin
                        next_q.bcnt = 5'd0;
                        next_q.rd = hdr[11:10] == MDIO_OP_READ;
                        next_q.ra = hdr[4:0];
                        if (hdr[13:12] == MDIO_START && hdr[9:5] == PHY_ADDR &&
                            (hdr[11:10] == MDIO_OP_READ || hdr[11:10] == MDIO_OP_WRITE)) begin
                            next_q.ms = PLS_TA;
                        end else begin
                            next_q.ms = PLS_SKIP;
                        end
                    end
                end
                PLS_TA: begin
                    next_q.bcnt = 5'd1;
                    if (q.rd) begin
                        next_q.mdio_oe = 1'b1; // drive the second turnaround bit low
                        next_q.mdio_o = 1'b0;
                    end
                    if (q.bcnt == 5'd1) begin
                        next_q.ms = PLS_DATA;
                        next_q.bcnt = 5'd0;
                        if (q.rd) begin
                            next_q.sh = rdv;
                            next_q.mdio_o = rdv[15];
                        end
                    end
                end
                PLS_DATA: begin
                    next_q.bcnt = 5'(q.bcnt + 5'd1);
                    if (q.rd) begin
                        next_q.sh = {q.sh[14:0], 1'b0};
                        next_q.mdio_o = q.sh[14];
                    end else begin
                        next_q.sh = wdat;
                    end
                    if (q.bcnt == MDIO_DATA_LAST) begin
                        next_q.ms = PLS_IDLE;
                        next_q.mdio_oe = 1'b0;
                        next_q.mdio_o = 1'b0;
                    end
                end
                PLS_SKIP: begin
                    next_q.bcnt = 5'(q.bcnt + 5'd1);
                    if (q.bcnt == MDIO_SKIP_LAST) begin
                        next_q.ms = PLS_IDLE;
                    end
                end
                default: next_q.ms = PLS_IDLE;
            endcase
        end

        // register writes; read-only offsets ignore them
        if (wr_stb) begin
            if (pls_is_rw(q.ra)) begin
                next_q.gp[q.ra] = wdat;
            end
            if (q.ra == OFF_PARTNER_ABILITY) begin
                if (next_page_view_i) begin
                    next_q.pnp = wdat;
                end else begin
                    next_q.gp[OFF_PARTNER_ABILITY] = wdat;
                end
            end
            if (q.ra == OFF_TEST_AND_SELFTEST_EXTENSION) begin
                next_q.gp[OFF_TEST_AND_SELFTEST_EXTENSION] = wdat & EXT_WRITABLE_MASK;
            end
            if (q.ra == OFF_TRANSCEIVER_CONTROL) begin
                next_q.gp[OFF_TRANSCEIVER_CONTROL] = wdat;
                next_q.run = wdat[TCR_SELFTEST_START_BIT];
                next_q.lat = 1'b0;
            end
        end

        // self-test generator with packet and gap pacing
        if (gen_fire) begin
            next_q.glfsr = pls_lfsr_step(q.glfsr, long_q);
            next_q.pcnt = 8'(q.pcnt + 8'd1);
            if (!cont_q && q.pcnt == 8'(PKT_NIBBLES - 8'd1)) begin
                next_q.gap = 1'b1;
                next_q.pcnt = 8'h00;
            end
        end else if (q.run && q.gap) begin
            next_q.pcnt = 8'(q.pcnt + 8'd1);
            if (cont_q || q.pcnt == 8'(GAP_CYCLES - 8'd1)) begin
                next_q.gap = 1'b0;
                next_q.pcnt = 8'h00;
            end
        end

        // checker: compare each drained word against the local sequence
        if (chk) begin
            next_q.clfsr = pls_lfsr_step(q.clfsr, long_q);
            if (mis) begin
                next_q.pass = 1'b0;
                next_q.lat = 1'b1;
                if (q.err != 8'hff) begin
                    next_q.err = 8'(q.err + 8'd1);
                end
            end else if (!q.lat && !(wr_stb && q.ra == OFF_TRANSCEIVER_CONTROL)) begin
                next_q.pass = 1'b1;
            end
        end

        // a fresh start reseeds both sides so they line up again
        if (start_rise) begin
            next_q.glfsr = wdat[TCR_LONG_SEQUENCE_SELECT_BIT] ? SEED_LONG : SEED_SHORT;
            next_q.clfsr = wdat[TCR_LONG_SEQUENCE_SELECT_BIT] ? SEED_LONG : SEED_SHORT;
            next_q.err = 8'h00;
            next_q.pass = 1'b0;
            next_q.pcnt = 8'h00;
            next_q.gap = 1'b0;
        end

        // two-entry receive buffer
        if (pop) begin
            next_q.b0 = q.b1;
        end
        if (push) begin
            if (q.fill == 2'd0 || (q.fill == 2'd1 && pop)) begin
                next_q.b0 = din;
            end else begin
                next_q.b1 = din;
            end
        end
        next_q.fill = 2'(q.fill + {1'b0, push} - {1'b0, pop});
        next_q.rx_dv = next_q.fill != 2'd0;
        next_q.in_rdy = next_q.fill != 2'd2;
        next_q.tx_rdy = next_q.gp[OFF_BASIC_MODE_CONTROL][BMC_LOOPBACK_BIT] ?
                        (next_q.in_rdy && !next_q.run) : 1'b1;

        // media transmit stays quiet while looped back
        next_q.med_en = !loop_q && (q.run ? gen_active : tx_en_i);
        next_q.med_d = loop_q ? 4'h0 : (q.run ? q.glfsr[3:0] : txd_i);
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.in_rdy <= 1'b1;
            q.tx_rdy <= 1'b1;
            q.glfsr <= SEED_SHORT;
            q.clfsr <= SEED_SHORT;
        end else if (clk_en_i) begin
            q <= next_q;
        end
    end

    assign mdio_o = q.mdio_o;
    assign mdio_oe_o = q.mdio_oe;
    assign tx_ready_o = q.tx_rdy;
    assign rx_dv_o = q.rx_dv;
    assign rxd_o = q.b0;
    assign media_tx_en_o = q.med_en;
    assign media_txd_o = q.med_d;

    // checks
    a_loop_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clk_en_i && loop_q && next_q.gp[OFF_BASIC_MODE_CONTROL][BMC_LOOPBACK_BIT]
        |=> !media_tx_en_o && media_txd_o == 4'h0) else $error("media driven during loopback");
    a_loop_status: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        q.ra == OFF_TRANSCEIVER_STATUS |-> rdv[TST_LOOPBACK_BIT] == loop_q)
        else $error("loopback status wrong");
    a_loop_route: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clk_en_i && loop_q && !q.run && tx_en_i && q.in_rdy |=> rx_dv_o)
        else $error("looped word not presented");
    a_err_count: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clk_en_i && mis && q.err != 8'hff && !start_rise |=> q.err == $past(q.err) + 8'd1)
        else $error("error count missed");
    a_fail_latch: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clk_en_i && mis ##1 (!wr_stb) [*3] |-> !q.pass && q.lat)
        else $error("failure not held");
    a_start_fail: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clk_en_i && start_rise |=> !q.pass && q.err == 8'h00 && q.run)
        else $error("start did not clear results");
    a_cont_send: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        clk_en_i && q.run && cont_q && !loop_q && !start_rise |=> media_tx_en_o)
        else $error("continuous mode paused");
    a_id_fixed: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        q.ra == OFF_IDENTIFIER_HIGH |-> rdv == ID_HIGH)
        else $error("identifier changed");
    a_ta_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        q.ms == PLS_TA && mdio_oe_o |-> !mdio_o)
        else $error("turnaround not low");
    c_loop_data: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        loop_q && pop && !q.run);
    c_bist_pass: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        $rose(q.pass));
    c_bist_fail: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        mis ##1 q.lat);
    c_stall_full: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        q.fill == 2'd2 && !rx_ready_i);
endmodule
`default_nettype wire

/* pls_pkg.sv */
/*
 * Shared constants for the loopback and pseudo-random self-test block:
 * management register offsets, field positions, reset values, serial
 * management frame codes and the sequence generator step.
 * Assumes a 5-bit register address space reached over the serial
 * management pins; no other bus is present.
 */
`default_nettype none
package pls_pkg;
    // register offsets
    localparam logic [4:0] OFF_BASIC_MODE_CONTROL = 5'h00;
    localparam logic [4:0] OFF_BASIC_MODE_STATUS = 5'h01;
    localparam logic [4:0] OFF_IDENTIFIER_HIGH = 5'h02;
    localparam logic [4:0] OFF_IDENTIFIER_LOW = 5'h03;
    localparam logic [4:0] OFF_AUTONEG_ADVERTISEMENT = 5'h04;
    localparam logic [4:0] OFF_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] OFF_AUTONEG_EXPANSION = 5'h06;
    localparam logic [4:0] OFF_AUTONEG_NEXT_PAGE_TRANSMIT = 5'h07;
    localparam logic [4:0] OFF_TRANSCEIVER_STATUS = 5'h10;
    localparam logic [4:0] OFF_INTERRUPT_CONTROL = 5'h11;
    localparam logic [4:0] OFF_INTERRUPT_STATUS = 5'h12;
    localparam logic [4:0] OFF_FALSE_CARRIER_COUNTER = 5'h14;
    localparam logic [4:0] OFF_RECEIVE_ERROR_COUNTER = 5'h15;
    localparam logic [4:0] OFF_CODING_SUBLAYER_CONFIG = 5'h16;
    localparam logic [4:0] OFF_REDUCED_MII_BYPASS_CONTROL = 5'h17;
    localparam logic [4:0] OFF_INDICATOR_DIRECT_CONTROL = 5'h18;
    localparam logic [4:0] OFF_TRANSCEIVER_CONTROL = 5'h19;
    localparam logic [4:0] OFF_TEN_MEG_STATUS_CONTROL = 5'h1a;
    localparam logic [4:0] OFF_TEST_AND_SELFTEST_EXTENSION = 5'h1b;
    localparam logic [4:0] OFF_ENERGY_DETECT_CONTROL = 5'h1d;

    // field positions
    localparam int BMC_LOOPBACK_BIT = 14;
    localparam int TST_LOOPBACK_BIT = 3;
    localparam int TCR_LONG_SEQUENCE_SELECT_BIT = 10;
    localparam int TCR_SELFTEST_STATUS_BIT = 9;
    localparam int TCR_SELFTEST_START_BIT = 8;
    localparam int EXT_SELFTEST_CONTINUOUS_BIT = 5;
    localparam int EXT_ERR_LSB = 8;
    localparam logic [15:0] EXT_WRITABLE_MASK = 16'h0037;

    // reset values
    localparam logic [15:0] RW_RESET = 16'h0000;
    localparam logic [14:0] SEED_LONG = 15'h7fff;
    localparam logic [14:0] SEED_SHORT = 15'h01ff;

    // serial management frame
    localparam logic [1:0] MDIO_START = 2'b01;
    localparam logic [1:0] MDIO_OP_READ = 2'b10;
    localparam logic [1:0] MDIO_OP_WRITE = 2'b01;
    localparam logic [4:0] MDIO_HDR_LAST = 5'd13;
    localparam logic [4:0] MDIO_DATA_LAST = 5'd15;
    localparam logic [4:0] MDIO_SKIP_LAST = 5'd17;

    typedef enum logic [2:0] {
        PLS_IDLE,
        PLS_HDR,
        PLS_TA,
        PLS_DATA,
        PLS_SKIP
    } pls_mdio_e;

    // one step of the 9- or 15-bit sequence generator
    function automatic logic [14:0] pls_lfsr_step(input logic [14:0] v, input logic lng);
        logic fb;
        fb = lng ? (v[14] ^ v[13]) : (v[8] ^ v[4]);
        return lng ? {v[13:0], fb} : {6'h00, v[7:0], fb};
    endfunction
endpackage
`default_nettype wire

/* pls_mac_model.sv */
/*
 * MAC model for the MII side of the self-test block.
 * Assumes the bench fills tx_q, reads rx_q and drives stall_i at the
 * falling edge of mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pls_mac_model (
    input wire logic mclk_i,
    input wire logic stall_i,
    input wire logic tx_ready_i,
    input wire logic rx_dv_i,
    input wire logic [3:0] rxd_i,
    output logic tx_en_o,
    output logic [3:0] txd_o,
    output logic rx_ready_o
);
    logic [3:0] tx_q[$];
    logic [3:0] rx_q[$];
    logic [3:0] junk;
    logic taken;

    initial begin
        tx_en_o = 1'b0;
        txd_o = 4'h0;
        rx_ready_o = 1'b1;
        taken = 1'b0;
    end

    // handshakes seen at the rising edge, before the block updates
    always @(posedge mclk_i) begin
        taken <= tx_en_o && tx_ready_i;
        if (rx_dv_i && rx_ready_o) begin
            rx_q.push_back(rxd_i);
        end
    end

    // word held until taken; idle data toggles so a stale nibble never matches
    always @(negedge mclk_i) begin
        if (taken) begin
            junk = tx_q.pop_front();
        end
        tx_en_o = (tx_q.size() != 0);
        txd_o = tx_en_o ? tx_q[0] : ~txd_o;
        rx_ready_o = !stall_i;
    end
endmodule
`default_nettype wire

/* pls_self_test_tb.sv */
/*
 * Bench for the loopback and self-test block: management frame tasks,
 * MAC model on the MII side, optional cable loop on the media side.
 * Assumes a pull-up on the management data line.
 */
`timescale 1ns/1ps
`default_nettype none
module pls_self_test_tb;
    import pls_pkg::*;
    localparam logic [15:0] IDH = 16'h1234;  // arbitrary identity value
    localparam logic [15:0] IDL = 16'h5678;  // arbitrary identity value
    localparam logic [15:0] ABIL = 16'h7800;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic mdc = 1'b0;
    logic m_oe = 1'b0;
    logic m_bit = 1'b1;
    logic np = 1'b0;
    logic lp = 1'b0;
    logic ext = 1'b0;
    logic bad = 1'b0;
    logic stall = 1'b0;
    logic [5:0] st = 6'h1f;  // remote fault set, jabber clear, to tell the two apart
    logic cm = 1'b0;
    logic [8:0] sv = SEED_SHORT[8:0];
    int bad_left = 0;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic mdio_o, mdio_oe, tx_en, tx_ready, rx_dv, rx_ready, m_tx_en;
    logic [3:0] txd, rxd, m_txd;
    wire logic mdio_w = mdio_oe ? mdio_o : (m_oe ? m_bit : 1'b1);

    // short packets and gaps keep the run brief
    pls_self_test #(.ID_HIGH(IDH), .ID_LOW(IDL), .ABILITY(ABIL), .PKT_NIBBLES(8'h08),
        .GAP_CYCLES(8'h04)) dut_u (
        .mclk_i(mclk), .rst_b_i(rst_b), .clk_en_i(1'b1), .mdc_i(mdc), .mdio_i(mdio_w),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .tx_en_i(tx_en), .txd_i(txd),
        .tx_ready_o(tx_ready), .rx_dv_o(rx_dv), .rxd_o(rxd), .rx_ready_i(rx_ready),
        .media_tx_en_o(m_tx_en), .media_txd_o(m_txd), .media_rx_dv_i(ext & m_tx_en),
        .media_rxd_i(m_txd ^ {4{bad}}), .link_i(st[0]), .speed_100_i(st[1]),
        .full_duplex_i(st[2]), .autoneg_complete_i(st[3]), .remote_fault_i(st[4]),
        .jabber_i(st[5]), .next_page_view_i(np));

    pls_mac_model mac_u (.mclk_i(mclk), .stall_i(stall), .tx_ready_i(tx_ready),
        .rx_dv_i(rx_dv), .rxd_i(rxd), .tx_en_o(tx_en), .txd_o(txd), .rx_ready_o(rx_ready));

    always #25 mclk = ~mclk;

    task automatic stop_test;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // one management bit, two cycles low then two high; sampled before the rise
    task automatic clk_bit(input logic drv, input logic b, output logic s);
        mdc = 1'b0;
        m_oe = drv;
        m_bit = b;
        repeat (2) @(negedge mclk);
        s = mdio_w;
        mdc = 1'b1;
        repeat (2) @(negedge mclk);
    endtask

    task automatic frame(input logic rd, input logic [4:0] a, input logic [15:0] wd,
        output logic [15:0] q);
        logic [13:0] hdr;
        logic s;
        hdr = {MDIO_START, rd ? MDIO_OP_READ : MDIO_OP_WRITE, 5'h01, a};
        repeat (32) clk_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
        clk_bit(!rd, 1'b1, s);
        clk_bit(!rd, 1'b0, s);
        for (int i = 15; i >= 0; i--) clk_bit(!rd, wd[i], q[i]);
        clk_bit(1'b0, 1'b1, s);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        frame(1'b0, a, d, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        frame(1'b1, a, 16'h0000, q);
        chk($sformatf("reg %h", a), e, q);
    endtask

    // hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    // line quiet in loopback; corrupt a counted number of cable nibbles
    always @(negedge mclk) begin
        if (lp) begin
            chk("media_tx", 16'h0000, {11'h000, m_tx_en, m_txd});
        end
        // own 9-bit model of the line sequence, restarted while the line is idle
        if (cm && m_tx_en) begin
            chk("media_txd_o", {12'h000, sv[3:0]}, {12'h000, m_txd});
            sv = {sv[7:0], sv[8] ^ sv[4]};
        end else begin
            sv = SEED_SHORT[8:0];
        end
        bad = ext && bad_left != 0 && m_tx_en;
        if (bad) begin
            bad_left--;
        end
    end

    initial begin
        int hi;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        // reset values, read-only and unmapped places
        rd_chk(OFF_TRANSCEIVER_CONTROL, 16'h0000);
        rd_chk(OFF_TEST_AND_SELFTEST_EXTENSION, 16'h0000);
        wr(OFF_IDENTIFIER_HIGH, 16'hffff);
        rd_chk(OFF_IDENTIFIER_HIGH, IDH);
        rd_chk(OFF_IDENTIFIER_LOW, IDL);
        wr(OFF_BASIC_MODE_STATUS, 16'h0000);
        rd_chk(OFF_BASIC_MODE_STATUS, ABIL | 16'h003d);
        rd_chk(5'h08, 16'h0000);
        wr(OFF_TEST_AND_SELFTEST_EXTENSION, 16'hffff);
        rd_chk(OFF_TEST_AND_SELFTEST_EXTENSION, 16'h0037);
        wr(OFF_TEST_AND_SELFTEST_EXTENSION, 16'h0000);
        // base and next page copies at one offset
        wr(OFF_PARTNER_ABILITY, 16'h1111);
        np = 1'b1;
        wr(OFF_PARTNER_ABILITY, 16'h2222);
        rd_chk(OFF_PARTNER_ABILITY, 16'h2222);
        np = 1'b0;
        rd_chk(OFF_PARTNER_ABILITY, 16'h1111);
        // loopback with auto-negotiation enable left clear, receiver stalled
        wr(OFF_BASIC_MODE_CONTROL, 16'h4000);
        lp = 1'b1;
        rd_chk(OFF_TRANSCEIVER_STATUS, 16'h005f);
        stall = 1'b1;
        for (int i = 1; i <= 8; i++) mac_u.tx_q.push_back(4'(i));
        repeat (8) @(negedge mclk);
        chk("tx_ready_o", 16'h0000, {15'h0000, tx_ready});
        stall = 1'b0;
        repeat (40) @(negedge mclk);
        chk("rx count", 16'h0008, 16'(mac_u.rx_q.size()));
        for (int i = 0; i < 8; i++) chk("rxd_o", 16'(i + 1), {12'h000, mac_u.rx_q[i]});
        // internal loop, both sequence lengths, stop keeps the result
        for (int l = 0; l < 2; l++) begin
            wr(OFF_TRANSCEIVER_CONTROL, l ? 16'h0500 : 16'h0100);
            repeat (80) @(negedge mclk);
            rd_chk(OFF_TRANSCEIVER_CONTROL, l ? 16'h0700 : 16'h0300);
            rd_chk(OFF_TEST_AND_SELFTEST_EXTENSION, 16'h0000);
            wr(OFF_TRANSCEIVER_CONTROL, 16'h0000);
            rd_chk(OFF_TRANSCEIVER_CONTROL, 16'h0200);
        end
        lp = 1'b0;
        wr(OFF_BASIC_MODE_CONTROL, 16'h0000);
        // cable loop, five corrupted nibbles, then the latch released by a write
        ext = 1'b1;
        bad_left = 5;
        wr(OFF_TRANSCEIVER_CONTROL, 16'h0100);
        repeat (80) @(negedge mclk);
        rd_chk(OFF_TRANSCEIVER_CONTROL, 16'h0100);
        rd_chk(OFF_TEST_AND_SELFTEST_EXTENSION, 16'h0500);
        wr(OFF_TRANSCEIVER_CONTROL, 16'h0100);
        repeat (40) @(negedge mclk);
        rd_chk(OFF_TRANSCEIVER_CONTROL, 16'h0300);
        // continuous mode: no gap after the packet length
        wr(OFF_TRANSCEIVER_CONTROL, 16'h0000);
        cm = 1'b1;
        wr(OFF_TEST_AND_SELFTEST_EXTENSION, 16'h0020);
        wr(OFF_TRANSCEIVER_CONTROL, 16'h0100);
        hi = 0;
        repeat (40) begin
            @(negedge mclk);
            hi += int'(m_tx_en === 1'b1);
        end
        chk("media_tx_en_o high", 16'h0028, 16'(hi));
        stop_test();
    end
endmodule
`default_nettype wire
